/* File: rtl/dib_pkg.sv */
// dib_pkg: shared constants for the ddr2 interbank command logic
package dib_pkg;
  // ****************************************
  // command codes on {ras_n, cas_n, we_n}
  // ****************************************
  localparam logic [2:0] CMD_NOP   = 3'h7; // all strobes high
  localparam logic [2:0] CMD_ACT   = 3'h3; // low-high-high
  localparam logic [2:0] CMD_READ  = 3'h5; // high-low-high
  localparam logic [2:0] CMD_WRITE = 3'h4; // high-low-low
  localparam logic [2:0] CMD_PRE   = 3'h2; // low-high-low
  localparam logic [2:0] CMD_REF   = 3'h1; // low-low-high
  localparam logic [2:0] CMD_MRL   = 3'h0; // low-low-low, mode register load
  // ****************************************
  // address fields
  // ****************************************
  localparam int AP_BIT       = 10; // auto precharge select
  localparam int BURST_LSB    = 0;  // burst length field low bit
  localparam int BURST_W      = 3;  // burst length field width
  localparam int RL_LSB       = 4;  // read latency field low bit
  localparam int RL_W         = 3;
  localparam logic [1:0] MR_MAIN = 2'h0; // bank code of main mode register
  localparam logic [1:0] MR_EXT1 = 2'h1; // bank code of first extended register
  localparam int PCD_LSB      = 3;  // posted delay field in extended register
  localparam int PCD_W        = 3;
  localparam logic [2:0] BURST_CODE4 = 3'h2; // burst of four
  localparam logic [2:0] BURST_CODE8 = 3'h3; // burst of eight
  localparam logic [12:0] MR_RESET = 13'h0002; // burst four after reset
  // ****************************************
  // timing, 20 MHz system clock
  // ****************************************
  localparam int CLK_PERIOD_NS  = 50;
  localparam int ACT_COL_NS     = 15;  // activate_to_column_delay
  localparam int PRE_PERIOD_NS  = 15;  // precharge_period
  localparam int WR_RECOVER_NS  = 15;  // write_recovery_time
  localparam int ACT_COL_CYC    = (ACT_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_PERIOD_CYC = (PRE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_RECOVER_CYC = (WR_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_PRE_GAP = 2;   // burst read to precharge gap, in half-burst units
  // ****************************************
  // bank state
  // ****************************************
  typedef enum logic [2:0] {
    DIB_IDLE, DIB_ACTIVATING, DIB_ACTIVE, DIB_READING, DIB_WRITING, DIB_RECOVER,
    DIB_PRECHARGING
  } dib_bank_e;
endpackage

/* File: rtl/dib_bank.sv */
// dib_bank: state and timer of one bank
module dib_bank (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        act_go,      // activate this bank
  input  wire logic        col_go,      // internal column command registered
  input  wire logic        col_wr,      // column command is a write
  input  wire logic        col_ap,      // column command asks auto precharge
  input  wire logic        pre_go,      // explicit precharge
  input  wire logic [4:0]  burst_cyc,   // clocks of data burst
  output dib_pkg::dib_bank_e state,
  output logic             row_active   // bank open, column access allowed
);
  // ****************************************
  // bank timer
  // ****************************************
  dib_pkg::dib_bank_e st_reg, st_next;
  logic [4:0] tmr_reg, tmr_next;    // cycles left in current phase
  logic       ap_reg, ap_next;      // auto precharge pending
  logic       wr_reg, wr_next;      // burst is a write
  wire        tmr_done = (tmr_reg <= 5'h1);
  assign state      = st_reg;
  assign row_active = (st_reg == dib_pkg::DIB_ACTIVE) || (st_reg == dib_pkg::DIB_READING)
                   || (st_reg == dib_pkg::DIB_WRITING);

  // next state of one bank
  always_comb begin
    st_next  = st_reg;
    tmr_next = (tmr_reg == 5'h0) ? 5'h0 : tmr_reg - 5'h1;
    ap_next  = ap_reg;
    wr_next  = wr_reg;
    unique case (st_reg)
      dib_pkg::DIB_IDLE: begin
        if (act_go) begin
          st_next  = dib_pkg::DIB_ACTIVATING;
          tmr_next = 5'(dib_pkg::ACT_COL_CYC);
        end
      end
      dib_pkg::DIB_ACTIVATING: begin
        if (tmr_done) st_next = dib_pkg::DIB_ACTIVE;
      end
      dib_pkg::DIB_RECOVER: begin
        // write recovery counted as with no auto precharge
        if (tmr_done) begin
          st_next  = dib_pkg::DIB_PRECHARGING;
          tmr_next = 5'(dib_pkg::PRE_PERIOD_CYC);
        end
      end
      dib_pkg::DIB_PRECHARGING: begin
        if (tmr_done) st_next = dib_pkg::DIB_IDLE;
      end
      default: begin // active, reading, writing
        if (pre_go && !ap_reg) begin
          st_next  = dib_pkg::DIB_PRECHARGING;
          tmr_next = 5'(dib_pkg::PRE_PERIOD_CYC);
        end else if (col_go) begin
          st_next  = col_wr ? dib_pkg::DIB_WRITING : dib_pkg::DIB_READING;
          tmr_next = burst_cyc;
          ap_next  = col_ap;
          wr_next  = col_wr;
        end else if (st_reg != dib_pkg::DIB_ACTIVE && tmr_done) begin
          if (!ap_reg) begin
            st_next = dib_pkg::DIB_ACTIVE;
          end else if (wr_reg) begin
            st_next  = dib_pkg::DIB_RECOVER;
            tmr_next = 5'(dib_pkg::WR_RECOVER_CYC);
          end else begin
            // read: precharge where the earliest explicit one would start
            st_next  = dib_pkg::DIB_PRECHARGING;
            tmr_next = 5'(dib_pkg::PRE_PERIOD_CYC);
          end
          ap_next = 1'b0;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg  <= dib_pkg::DIB_IDLE;
      tmr_reg <= 5'h0;
      ap_reg  <= 1'b0;
      wr_reg  <= 1'b0;
    end else begin
      st_reg  <= st_next;
      tmr_reg <= tmr_next;
      ap_reg  <= ap_next;
      wr_reg  <= wr_next;
    end
  end

  AST_ACT_TO_ACTIVE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == dib_pkg::DIB_IDLE && act_go) |=> ##[1:4] (st_reg == dib_pkg::DIB_ACTIVE))
    else $error("bank did not open after activate");
  AST_WR_RECOVER: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == dib_pkg::DIB_RECOVER && tmr_done) |=> (st_reg == dib_pkg::DIB_PRECHARGING))
    else $error("write recovery did not lead to precharge");
  AST_RD_AP_PRE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_reg == dib_pkg::DIB_READING && ap_reg && tmr_done && !col_go && !pre_go)
      |=> (st_reg == dib_pkg::DIB_PRECHARGING))
    else $error("read auto precharge did not start");
endmodule

/* File: rtl/dib_cmd.sv */
// dib_cmd: command decode, mode registers and bank tracking of a ddr2 device
// Notes on behaviour
// - chip select high ignores new commands
// - all strobes high is a no-operation
// - strobe patterns decode to activate, read, write, precharge and mode load
// - accept other-bank commands during auto precharge
// - read auto precharge starts at earliest precharge
// - write auto precharge starts after write recovery
// - mode load: bank picks register, address supplies data
// - activate opens row until bank precharged
// - address bit ten selects auto precharge
// - read takes bank and starting column
// - posted delay postpones internal column registration
// - bank active only after activate-to-column delay
// - burst length from mode bits, four or eight
module dib_cmd #(
  parameter int NUM_BANKS = 4,   // bank count
  parameter int ADDR_W    = 13,  // address inputs
  parameter int COL_W     = 10,  // column bits
  parameter int POST_MAX  = 7    // deepest posted delay supported
) (
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  input  wire logic                         cke_pin,       // clock enable pin
  input  wire logic                         cs_n_pin,      // chip select, active low
  input  wire logic                         ras_n_pin,
  input  wire logic                         cas_n_pin,
  input  wire logic                         we_n_pin,
  input  wire logic [$clog2(NUM_BANKS)-1:0] ba_pin,        // bank address
  input  wire logic [ADDR_W-1:0]            addr_pin,      // address inputs
  output logic                              int_col_valid, // internal column command
  output logic                              int_col_write,
  output logic                              int_col_ap,
  output logic [$clog2(NUM_BANKS)-1:0]      int_col_bank,
  output logic [COL_W-1:0]                  int_col_addr,
  output logic [ADDR_W-1:0]                 open_row [NUM_BANKS],
  output logic [NUM_BANKS-1:0]              bank_active,   // row open per bank
  output logic [NUM_BANKS-1:0]              bank_idle,
  output logic [3:0]                        burst_length_setting,
  output logic [2:0]                        read_latency,
  output logic [2:0]                        posted_command_delay,
  output logic [ADDR_W-1:0]                 mode_main,
  output logic [ADDR_W-1:0]                 mode_ext1
);
  localparam int BA_W = $clog2(NUM_BANKS);
  // column bits must stay below the auto precharge bit; the tap is three bits wide
  if (COL_W > dib_pkg::AP_BIT || ADDR_W <= dib_pkg::AP_BIT || POST_MAX > 7 || POST_MAX < 1
      || NUM_BANKS < 2) begin : g_bad_params
    $error("dib_cmd: unsupported parameters");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int PIN_W = 5 + BA_W + ADDR_W;
  logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg; // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_meta_reg <= '1;
      pin_sync_reg <= '1;
    end else begin
      pin_meta_reg <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  logic cke_prev_reg; // clock enable one cycle back
  always_ff @(posedge clk_sys) begin
    if (!resetn) cke_prev_reg <= 1'b0;
    else         cke_prev_reg <= pin_sync_reg[PIN_W-1];
  end
  wire              cke_now  = pin_sync_reg[PIN_W-1];
  wire              cs_n     = pin_sync_reg[PIN_W-2];
  wire [2:0]        strobes  = pin_sync_reg[PIN_W-3 -: 3];
  wire [BA_W-1:0]   cmd_bank = pin_sync_reg[ADDR_W +: BA_W];
  wire [ADDR_W-1:0] cmd_addr = pin_sync_reg[ADDR_W-1:0];
  // commands count only with clock enable high now and before
  wire cmd_ok   = cke_now && cke_prev_reg && !cs_n;
  wire is_nop   = (strobes == dib_pkg::CMD_NOP);
  wire is_act   = cmd_ok && (strobes == dib_pkg::CMD_ACT);
  wire is_read  = cmd_ok && (strobes == dib_pkg::CMD_READ);
  wire is_write = cmd_ok && (strobes == dib_pkg::CMD_WRITE);
  wire is_pre   = cmd_ok && (strobes == dib_pkg::CMD_PRE);
  wire is_mrl   = cmd_ok && (strobes == dib_pkg::CMD_MRL) && (&bank_idle);
  wire is_col   = is_read || is_write;
  wire pre_all  = cmd_addr[dib_pkg::AP_BIT]; // precharge every bank

  // ****************************************
  // mode registers
  // ****************************************
  logic [ADDR_W-1:0] mode_main_reg, mode_ext1_reg;
  // bank address selects register, address carries contents
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_main_reg <= ADDR_W'(dib_pkg::MR_RESET);
      mode_ext1_reg <= '0;
    end else if (is_mrl) begin
      if (2'(cmd_bank) == dib_pkg::MR_MAIN) mode_main_reg <= cmd_addr;
      if (2'(cmd_bank) == dib_pkg::MR_EXT1) mode_ext1_reg <= cmd_addr;
    end
  end
  assign mode_main = mode_main_reg;
  assign mode_ext1 = mode_ext1_reg;
  wire [2:0] burst_code = mode_main_reg[dib_pkg::BURST_LSB +: dib_pkg::BURST_W];
  // only four and eight are served; any other code falls back to four
  assign burst_length_setting = (burst_code == dib_pkg::BURST_CODE8) ? 4'h8 : 4'h4;
  assign read_latency         = mode_main_reg[dib_pkg::RL_LSB +: dib_pkg::RL_W];
  wire [2:0] pcd_raw = mode_ext1_reg[dib_pkg::PCD_LSB +: dib_pkg::PCD_W];
  assign posted_command_delay = (pcd_raw > 3'(POST_MAX)) ? 3'(POST_MAX) : pcd_raw;
  wire [4:0] burst_cyc = {2'h0, burst_length_setting[3:1]}; // half the burst

  // ****************************************
  // posted column command delay line
  // ****************************************
  // one slot per cycle of delay; a column command can arrive every cycle
  localparam int CW = 2 + BA_W + COL_W;
  logic [CW-1:0]     post_data_reg [POST_MAX+1];
  logic [POST_MAX:0] post_vld_reg;
  wire  [CW-1:0]     col_word = {is_write, cmd_addr[dib_pkg::AP_BIT], cmd_bank,
                                 cmd_addr[COL_W-1:0]};
  // shift every cycle; the tap picks the programmed delay
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      post_vld_reg <= '0;
      for (int i = 0; i <= POST_MAX; i++) post_data_reg[i] <= '0;
    end else begin
      post_vld_reg[0]  <= is_col;
      post_data_reg[0] <= col_word;
      for (int i = 1; i <= POST_MAX; i++) begin
        post_vld_reg[i]  <= post_vld_reg[i-1];
        post_data_reg[i] <= post_data_reg[i-1];
      end
    end
  end
  // zero delay takes the command straight from decode
  wire          tap_zero = (posted_command_delay == 3'h0);
  wire          tap_vld  = tap_zero ? is_col : post_vld_reg[posted_command_delay - 3'h1];
  wire [CW-1:0] tap_data = tap_zero ? col_word : post_data_reg[posted_command_delay - 3'h1];
  wire [BA_W-1:0] tap_bank = tap_data[COL_W +: BA_W];

  // registered internal column command
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      int_col_valid <= 1'b0;
      int_col_write <= 1'b0;
      int_col_ap    <= 1'b0;
      int_col_bank  <= '0;
      int_col_addr  <= '0;
    end else begin
      int_col_valid <= tap_vld && bank_active[tap_bank];
      int_col_write <= tap_data[CW-1];
      int_col_ap    <= tap_data[CW-2];
      int_col_bank  <= tap_bank;
      int_col_addr  <= tap_data[COL_W-1:0];
    end
  end

  // ****************************************
  // banks
  // ****************************************
  // each bank takes commands addressed to it; others keep running untouched, except on precharge all
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    wire hit = (cmd_bank == BA_W'(b));
    dib_pkg::dib_bank_e bst;
    dib_bank u_bank (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .act_go     (is_act && hit),
      .col_go     (tap_vld && tap_bank == BA_W'(b)),
      .col_wr     (tap_data[CW-1]),
      .col_ap     (tap_data[CW-2]),
      .pre_go     (is_pre && (hit || pre_all)),
      .burst_cyc  (burst_cyc),
      .state      (bst),
      .row_active (bank_active[b])
    );
    assign bank_idle[b] = (bst == dib_pkg::DIB_IDLE);
    // row latched on activate, held until the next activate
    always_ff @(posedge clk_sys) begin
      if (!resetn)                              open_row[b] <= '0;
      else if (is_act && hit && bank_idle[b])   open_row[b] <= cmd_addr;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_DESELECT_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cs_n && tap_zero) |=> !int_col_valid)
    else $error("column command taken while deselected");
  AST_NOP_NO_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_nop || cs_n) |=> $stable(mode_main_reg) && $stable(mode_ext1_reg))
    else $error("mode register changed on no-operation");
  AST_WRITE_DECODE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_write && tap_zero && bank_active[cmd_bank]) |=> (int_col_valid && int_col_write))
    else $error("write not decoded");
  AST_MODE_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_mrl && 2'(cmd_bank) == dib_pkg::MR_MAIN) |=> (mode_main_reg == $past(cmd_addr)))
    else $error("main mode register not loaded");
  AST_AP_BIT: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_read && tap_zero) |=> (int_col_ap == $past(cmd_addr[dib_pkg::AP_BIT])))
    else $error("auto precharge bit lost");
  AST_BURST_LEN: assert property (@(posedge clk_sys) disable iff (!resetn)
    (burst_length_setting == 4'h4) || (burst_length_setting == 4'h8))
    else $error("burst length not four or eight");
  AST_POSTED: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_col && posted_command_delay == 3'h2 && $stable(posted_command_delay))
      |-> ##2 tap_vld)
    else $error("posted column command not delayed");
  AST_OTHER_BANK: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_act && bank_idle[cmd_bank] && !(&bank_idle))
      |=> !bank_idle[$past(cmd_bank)])
    else $error("activate refused while other bank busy");
endmodule

/* File: verif/dib_ctl_model.sv */
// dib_ctl_model: behavioural ddr2 controller driving the command pins
module dib_ctl_model #(
  parameter int MODE_SET_CYC = 2,  // mode_set_delay in clocks, plain default
  parameter int WR_RD_GAP_NS = 10  // write_to_read_gap in ns, plain default
) (
  input  wire logic        clk_sys,
  output logic             cke_pin,
  output logic             cs_n_pin,
  output logic             ras_n_pin,
  output logic             cas_n_pin,
  output logic             we_n_pin,
  output logic [1:0]       ba_pin,
  output logic [12:0]      addr_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // write-to-read turnaround, never under two clocks
  localparam int WR_RD_CYC =
    (WR_RD_GAP_NS + dib_pkg::CLK_PERIOD_NS - 1) / dib_pkg::CLK_PERIOD_NS;
  localparam int WR_RD_TURN = (WR_RD_CYC > 2) ? WR_RD_CYC : 2;
  // spacing after an auto-precharge write before a read elsewhere, in clocks
  function automatic int wr_ap_to_rd(input int rl, input int bl);
    return (rl - 1) + bl / 2 + WR_RD_TURN;
  endfunction
  // spacing between like column commands to different banks
  function automatic int half_burst(input int bl);
    return bl / 2;
  endfunction
  // ****************************************
  // pin drive
  // ****************************************
  // clock enable never drops, so it never blocks a command; deselected ones still do not count
  initial begin
    cke_pin = 1'b1;
    cs_n_pin = 1'b1;
    {ras_n_pin, cas_n_pin, we_n_pin} = dib_pkg::CMD_NOP;
    ba_pin = 2'h0;
    addr_pin = 13'h0000;
  end
  // one command cycle, then nop; spacing between banks chosen by the caller
  task automatic issue(input logic [2:0] cmd, input logic [1:0] ba,
                       input logic [12:0] a, input logic sel, input int gap);
    @(posedge clk_sys);
    #1;
    cs_n_pin = ~sel;
    {ras_n_pin, cas_n_pin, we_n_pin} = cmd;
    ba_pin = ba;
    addr_pin = a;
    @(posedge clk_sys);
    #1;
    cs_n_pin = 1'b0;
    {ras_n_pin, cas_n_pin, we_n_pin} = dib_pkg::CMD_NOP;
    // lines no longer carry a command, so show no stale value
    ba_pin = ~ba;
    addr_pin = ~a;
    // nothing executable until the mode set delay has run out
    if (cmd === dib_pkg::CMD_MRL) repeat (MODE_SET_CYC) @(posedge clk_sys);
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule

/* File: verif/ddr2_interbank_command_rules_tb.sv */
// ddr2_interbank_command_rules_tb: self-checking bench of the command logic
module ddr2_interbank_command_rules_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic        clk_sys;
  logic        resetn;
  logic        cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
  logic [1:0]  ba_pin;
  logic [12:0] addr_pin;
  logic        int_col_valid, int_col_write, int_col_ap;
  logic [1:0]  int_col_bank;
  logic [9:0]  int_col_addr;
  logic [12:0] open_row [4];
  logic [3:0]  bank_active, bank_idle, burst_length_setting;
  logic [2:0]  read_latency, posted_command_delay;
  logic [12:0] mode_main, mode_ext1;
  int          failures = 0;    // mismatches seen
  int          n_compared = 0;  // comparisons made
  int          cycles = 0;      // hang guard
  int          n_col = 0;       // internal column pulses seen
  int          n_col_wr = 0;    // of which writes
  // controller on the far side
  dib_ctl_model model (.clk_sys(clk_sys), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin),
    .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin),
    .ba_pin(ba_pin), .addr_pin(addr_pin));
  dib_cmd dut (.clk_sys(clk_sys), .resetn(resetn), .cke_pin(cke_pin),
    .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin),
    .we_n_pin(we_n_pin), .ba_pin(ba_pin), .addr_pin(addr_pin),
    .int_col_valid(int_col_valid), .int_col_write(int_col_write),
    .int_col_ap(int_col_ap), .int_col_bank(int_col_bank), .int_col_addr(int_col_addr),
    .open_row(open_row), .bank_active(bank_active), .bank_idle(bank_idle),
    .burst_length_setting(burst_length_setting), .read_latency(read_latency),
    .posted_command_delay(posted_command_delay), .mode_main(mode_main),
    .mode_ext1(mode_ext1));
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // case equality so an unknown never matches
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // tally internal column pulses; values read are those before the edge
  always @(posedge clk_sys) begin
    if (int_col_valid === 1'b1) n_col++;
    if (int_col_valid === 1'b1 && int_col_write === 1'b1) n_col_wr++;
  end
  // bounded wait for a bank to fall idle
  task automatic wait_idle(input int b, input int lim, input string what);
    int k;
    k = 0;
    while (bank_idle[b] !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
    chk(bank_idle[b], 1'b1, what);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk(mode_main, dib_pkg::MR_RESET, "main reset");
    chk(mode_ext1, 16'h0000, "ext reset");
    chk(bank_idle, 4'hf, "idle reset");
    chk(burst_length_setting, 4'h4, "burst four");
    model.issue(dib_pkg::CMD_ACT, 2'h0, 13'h0055, 1'b0, 0);
    tick(4);
    chk(bank_idle, 4'hf, "deselect ignored");
    model.issue(dib_pkg::CMD_NOP, 2'h0, 13'h0055, 1'b1, 0);
    tick(4);
    chk(bank_idle, 4'hf, "nop ignored");
    chk(int_col_valid, 1'b0, "no column");
    $display("test reset done");
  endtask
  // activate then read with auto precharge, deselected precharge mid-burst
  task automatic t_act_read;
    model.issue(dib_pkg::CMD_ACT, 2'h1, 13'h1abc, 1'b1, 0);
    tick(2);
    chk(bank_idle[1], 1'b0, "left idle");
    chk(bank_active[1], 1'b0, "not yet active");
    tick(1);
    chk(bank_active[1], 1'b1, "active");
    chk(open_row[1], 13'h1abc, "row");
    model.issue(dib_pkg::CMD_READ, 2'h1, 13'h05f4, 1'b1, 0);
    model.issue(dib_pkg::CMD_PRE, 2'h1, 13'h0000, 1'b0, 0);
    chk(int_col_valid, 1'b1, "read taken");
    chk(int_col_write, 1'b0, "read kind");
    chk(int_col_ap, 1'b1, "read ap");
    chk(int_col_bank, 2'h1, "read bank");
    chk(int_col_addr, 10'h1f4, "read column");
    tick(1);
    chk(bank_idle[1], 1'b0, "burst runs on");
    wait_idle(1, 6, "closed after burst");
    $display("test activate read done");
  endtask
  // write with auto precharge, other bank opened two cycles later
  task automatic t_concurrent;
    model.issue(dib_pkg::CMD_ACT, 2'h2, 13'h0123, 1'b1, 1);
    model.issue(dib_pkg::CMD_WRITE, 2'h2, 13'h0410, 1'b1, 0);
    model.issue(dib_pkg::CMD_ACT, 2'h3, 13'h0777, 1'b1, 0);
    chk(int_col_valid, 1'b1, "write taken");
    chk(int_col_write, 1'b1, "write kind");
    chk(int_col_ap, 1'b1, "write ap");
    chk(int_col_bank, 2'h2, "write bank");
    tick(3);
    chk(bank_active[3], 1'b1, "other bank opened");
    chk(open_row[3], 13'h0777, "other row");
    wait_idle(2, 10, "write closed");
    model.issue(dib_pkg::CMD_PRE, 2'h3, 13'h0000, 1'b1, 0);
    wait_idle(3, 6, "precharged");
    $display("test concurrent done");
  endtask
  // mode loads, posted delay, refused load with a bank open
  task automatic t_mode;
    model.issue(dib_pkg::CMD_MRL, dib_pkg::MR_MAIN, 13'h0033, 1'b1, 0);
    tick(1);
    chk(mode_main, 13'h0033, "main load");
    chk(burst_length_setting, 4'h8, "burst eight");
    chk(read_latency, 3'h3, "latency");
    model.issue(dib_pkg::CMD_MRL, dib_pkg::MR_EXT1, 13'h0010, 1'b1, 0);
    tick(1);
    chk(mode_ext1, 13'h0010, "ext load");
    chk(mode_main, 13'h0033, "main kept");
    chk(posted_command_delay, 3'h2, "posted delay");
    model.issue(dib_pkg::CMD_ACT, 2'h0, 13'h0042, 1'b1, 2);
    model.issue(dib_pkg::CMD_READ, 2'h0, 13'h0033, 1'b1, 0);
    tick(2);
    chk(int_col_valid, 1'b0, "held back");
    tick(2);
    chk(int_col_valid, 1'b1, "posted read");
    chk(int_col_ap, 1'b0, "no ap");
    tick(8);
    chk(bank_active[0], 1'b1, "row kept open");
    // deliberate load with a bank open must be dropped
    model.issue(dib_pkg::CMD_MRL, dib_pkg::MR_MAIN, 13'h0002, 1'b1, 0);
    tick(1);
    chk(mode_main, 13'h0033, "load refused");
    // precharge all, addressed to an idle bank, must still close bank0
    model.issue(dib_pkg::CMD_PRE, 2'h1, 13'h0400, 1'b1, 0);
    wait_idle(0, 6, "bank0 closed");
    $display("test mode done");
  endtask
  // auto-precharge write, then other-bank write and read at rule spacing
  task automatic t_spacing;
    int c0, w0, g_wr, g_rd;
    c0 = n_col;
    w0 = n_col_wr;
    g_wr = model.half_burst(8);
    g_rd = model.wr_ap_to_rd(3, 8);
    model.issue(dib_pkg::CMD_ACT, 2'h1, 13'h0111, 1'b1, 0);
    model.issue(dib_pkg::CMD_ACT, 2'h2, 13'h0222, 1'b1, 1);
    model.issue(dib_pkg::CMD_WRITE, 2'h1, 13'h0408, 1'b1, g_wr);
    model.issue(dib_pkg::CMD_WRITE, 2'h2, 13'h0020, 1'b1, g_rd);
    model.issue(dib_pkg::CMD_READ, 2'h2, 13'h0010, 1'b1, 0);
    tick(8);
    chk(n_col - c0, 16'h0003, "column commands taken");
    chk(n_col_wr - w0, 16'h0002, "writes taken");
    chk(bank_idle[1], 1'b1, "write ap bank closed");
    chk(bank_active[2], 1'b1, "other bank open");
    chk(open_row[2], 13'h0222, "other row");
    model.issue(dib_pkg::CMD_PRE, 2'h2, 13'h0000, 1'b1, 0);
    wait_idle(2, 6, "bank2 closed");
    $display("test spacing done");
  endtask
  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 120 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
    end
  end
  initial begin
    resetn = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    tick(3);
    t_reset();
    t_act_read();
    t_concurrent();
    t_mode();
    t_spacing();
    wrap_up();
  end
endmodule
